/* logic/sfcc_pkg.sv */
// Purpose: Shared constants for the sense fault and calibration control block
// Assumes: 250 MHz register clock, 16-bit serial frames
// Notes: Addresses are 6-bit register indices carried in the serial frame
`default_nettype none
package sfcc_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int GATE_DRIVE_WINDOW_NS = 4000;
	localparam int GATE_DRIVE_WINDOW_CYC = GATE_DRIVE_WINDOW_NS / CLK_PERIOD_NS;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [5:0] ADDR_SENSE_CAL_CTRL = 6'h10;
	localparam logic [5:0] ADDR_CAL_MODE = 6'h11;
	localparam logic [5:0] ADDR_HS_DRIVE = 6'h12;
	localparam logic [5:0] ADDR_LS_DRIVE = 6'h13;
	localparam logic [5:0] ADDR_GATE_FAULT = 6'h14;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_SENSE_CAL_CTRL = 8'h00;
	localparam logic [7:0] RST_CAL_MODE = 8'h00;
	localparam logic [7:0] RST_DRIVE = 8'h00;
	localparam logic [5:0] RST_GATE_FAULT = 6'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FLD_CAL_LSB = 0;
	localparam int FLD_SENSE_OFF_LSB = 3;
	localparam int FLD_CAL_MODE = 7;
	localparam int FLD_SOURCE_LSB = 0;
	localparam int FLD_SINK_LSB = 4;
	// ----------------------------------------
	// Serial frame layout
	// ----------------------------------------
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0f;
	localparam logic [4:0] FRAME_ADDR_DONE = 5'h07;
	localparam int FRM_READ = 15;
	localparam int FRM_ADDR_MSB = 14;
	localparam int FRM_ADDR_LSB = 9;
	// ----------------------------------------
	// Gate monitor states
	// ----------------------------------------
	typedef enum logic [1:0] {
		GM_IDLE,
		GM_TURNING_ON,
		GM_ON,
		GM_FAULT
	} sfcc_gate_state_t;
endpackage
`default_nettype wire

/* logic/sfcc_gate_monitor.sv */
// Purpose: Watches one gate for full turn-on within the drive window
// Assumes: Command and turned-on inputs synchronous to the clock
// Notes: Fault pulses once per command that misses the window
`default_nettype none
module sfcc_gate_monitor import sfcc_pkg::*; #(
	parameter int WINDOW_CYC = GATE_DRIVE_WINDOW_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Gate status
	input wire logic gate_cmd_in,
	input wire logic gate_on_in,
	// Fault
	output logic fault_out
);
	localparam int CW = $clog2(WINDOW_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(WINDOW_CYC - 1);
	sfcc_gate_state_t state_reg, state_next;
	logic [CW-1:0] count_reg;
	wire expired = (count_reg == LAST);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			GM_IDLE: if (gate_cmd_in) state_next = GM_TURNING_ON;
			GM_TURNING_ON: begin
				if (!gate_cmd_in) state_next = GM_IDLE;
				else if (gate_on_in) state_next = GM_ON;
				else if (expired) state_next = GM_FAULT;
			end
			GM_ON: if (!gate_cmd_in) state_next = GM_IDLE;
			GM_FAULT: if (!gate_cmd_in) state_next = GM_IDLE;
			default: state_next = GM_IDLE;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_reg <= GM_IDLE;
			count_reg <= '0;
			fault_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= (state_reg == GM_TURNING_ON) ? count_reg + 1'b1 : '0;
			fault_out <= (state_reg == GM_TURNING_ON) && (state_next == GM_FAULT);
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_gate_fault_due;
		@(posedge clk_in) disable iff (!resetn_in)
		(state_reg == GM_TURNING_ON && expired && gate_cmd_in && !gate_on_in) |=> fault_out;
	endproperty
	a_gate_fault_due: assert property (p_gate_fault_due) else $error("gate fault missed");
	property p_gate_fault_cause;
		@(posedge clk_in) disable iff (!resetn_in)
		fault_out |-> $past(gate_cmd_in) && !$past(gate_on_in) && state_reg == GM_FAULT;
	endproperty
	a_gate_fault_cause: assert property (p_gate_fault_cause) else $error("spurious gate fault");
endmodule
`default_nettype wire

/* logic/sfcc_top.sv */
// Purpose: Sense fault disable, amplifier calibration and gate drive control registers
// Assumes: Serial pins synchronous to clk_in, clk_in much faster than sclk_in
// Notes: Serial mode 1, 16-bit frames, read data returned in the second byte
`default_nettype none
module sfcc_top import sfcc_pkg::*; #(
	parameter bit SERIAL_VARIANT = 1'b1,
	parameter int WINDOW_CYC = GATE_DRIVE_WINDOW_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Serial interface
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe_out,
	// Sense overcurrent
	input wire logic [2:0] sense_overcurrent_in,
	output logic [2:0] sense_fault_out,
	output logic [2:0] sense_fault_off_out,
	// Amplifier calibration
	output logic [2:0] amp_input_short_out,
	output logic [2:0] amp_auto_cal_out,
	// Gate drive
	input wire logic [3:0] drive_strength_pin_in,
	input wire logic [5:0] gate_cmd_in,
	input wire logic [5:0] gate_on_in,
	output logic [3:0] hs_gate_source_current_out,
	output logic [3:0] hs_gate_sink_current_out,
	output logic [3:0] ls_gate_source_current_out,
	output logic [3:0] ls_gate_sink_current_out,
	output logic [5:0] gate_drive_fault_out
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] mode_reg, mode_next;
	logic [7:0] hs_reg, hs_next;
	logic [7:0] ls_reg, ls_next;
	logic [5:0] gfault_reg, gfault_next;
	logic [15:0] rx_reg;
	logic [7:0] tx_reg;
	logic [4:0] bit_reg;
	logic sclk_q_reg;
	logic [5:0] gate_fault_pulse;
	// ----------------------------------------
	// Serial decode
	// ----------------------------------------
	function automatic logic [7:0] read_mux(input logic [5:0] a, input logic [7:0] c,
			input logic [7:0] m, input logic [7:0] h, input logic [7:0] l, input logic [5:0] g);
		case (a)
			ADDR_SENSE_CAL_CTRL: read_mux = c;
			ADDR_CAL_MODE: read_mux = m;
			ADDR_HS_DRIVE: read_mux = h;
			ADDR_LS_DRIVE: read_mux = l;
			ADDR_GATE_FAULT: read_mux = {2'h0, g};
			default: read_mux = 8'h00;
		endcase
	endfunction
	wire active = !cs_n_in;
	wire sclk_rise = active && sclk_in && !sclk_q_reg;
	wire sclk_fall = active && !sclk_in && sclk_q_reg;
	wire [15:0] frame_word = {rx_reg[14:0], mosi_in};
	wire [5:0] wr_addr = frame_word[FRM_ADDR_MSB:FRM_ADDR_LSB];
	wire [7:0] wr_data = frame_word[7:0];
	wire commit = sclk_fall && (bit_reg == FRAME_LAST_BIT) && !frame_word[FRM_READ];
	wire addr_done = sclk_fall && (bit_reg == FRAME_ADDR_DONE);
	wire [5:0] rd_addr = rx_reg[5:0];
	wire [7:0] rd_data = read_mux(rd_addr, ctrl_reg, mode_reg, hs_reg, ls_reg, gfault_reg);
	wire fault_read = addr_done && rx_reg[6] && (rd_addr == ADDR_GATE_FAULT);
	wire wr_ctrl = commit && (wr_addr == ADDR_SENSE_CAL_CTRL);
	wire wr_mode = commit && (wr_addr == ADDR_CAL_MODE);
	wire wr_hs = commit && (wr_addr == ADDR_HS_DRIVE) && SERIAL_VARIANT;
	wire wr_ls = commit && (wr_addr == ADDR_LS_DRIVE) && SERIAL_VARIANT;
	// ----------------------------------------
	// Register next values
	// ----------------------------------------
	assign ctrl_next = wr_ctrl ? wr_data : ctrl_reg;
	assign mode_next = wr_mode ? wr_data : mode_reg;
	assign hs_next = wr_hs ? wr_data : hs_reg;
	assign ls_next = wr_ls ? wr_data : ls_reg;
	assign gfault_next = gate_fault_pulse | (fault_read ? 6'h00 : gfault_reg);
	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	wire [2:0] sense_off = ctrl_reg[FLD_SENSE_OFF_LSB +: 3];
	wire [2:0] cal_bits = ctrl_reg[FLD_CAL_LSB +: 3];
	wire auto_mode = mode_reg[FLD_CAL_MODE];
	wire [2:0] short_next = auto_mode ? 3'h0 : cal_bits;
	wire [2:0] auto_next = auto_mode ? cal_bits : 3'h0;
	wire [3:0] hs_src = SERIAL_VARIANT ? hs_reg[FLD_SOURCE_LSB +: 4] : drive_strength_pin_in;
	wire [3:0] hs_snk = SERIAL_VARIANT ? hs_reg[FLD_SINK_LSB +: 4] : drive_strength_pin_in;
	wire [3:0] ls_src = SERIAL_VARIANT ? ls_reg[FLD_SOURCE_LSB +: 4] : drive_strength_pin_in;
	wire [3:0] ls_snk = SERIAL_VARIANT ? ls_reg[FLD_SINK_LSB +: 4] : drive_strength_pin_in;
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			ctrl_reg <= RST_SENSE_CAL_CTRL;
			mode_reg <= RST_CAL_MODE;
			hs_reg <= RST_DRIVE;
			ls_reg <= RST_DRIVE;
			gfault_reg <= RST_GATE_FAULT;
		end else begin
			ctrl_reg <= ctrl_next;
			mode_reg <= mode_next;
			hs_reg <= hs_next;
			ls_reg <= ls_next;
			gfault_reg <= gfault_next;
		end
	end
	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sclk_q_reg <= 1'b0;
			rx_reg <= 16'h0000;
			tx_reg <= 8'h00;
			bit_reg <= 5'h00;
			miso_out <= 1'b0;
			miso_oe_out <= 1'b0;
		end else begin
			sclk_q_reg <= sclk_in;
			miso_oe_out <= active;
			if (!active) begin
				bit_reg <= 5'h00;
				tx_reg <= 8'h00;
				miso_out <= 1'b0;
			end else begin
				if (sclk_fall) begin
					rx_reg <= frame_word;
					bit_reg <= bit_reg + 5'h01;
				end
				if (addr_done) begin
					tx_reg <= rd_data;
				end else if (sclk_rise && bit_reg > FRAME_ADDR_DONE) begin
					miso_out <= tx_reg[7];
					tx_reg <= {tx_reg[6:0], 1'b0};
				end
			end
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sense_fault_out <= 3'h0;
			sense_fault_off_out <= 3'h0;
			amp_input_short_out <= 3'h0;
			amp_auto_cal_out <= 3'h0;
			hs_gate_source_current_out <= 4'h0;
			hs_gate_sink_current_out <= 4'h0;
			ls_gate_source_current_out <= 4'h0;
			ls_gate_sink_current_out <= 4'h0;
			gate_drive_fault_out <= 6'h00;
		end else begin
			sense_fault_out <= sense_overcurrent_in & ~sense_off;
			sense_fault_off_out <= sense_off;
			amp_input_short_out <= short_next;
			amp_auto_cal_out <= auto_next;
			hs_gate_source_current_out <= hs_src;
			hs_gate_sink_current_out <= hs_snk;
			ls_gate_source_current_out <= ls_src;
			ls_gate_sink_current_out <= ls_snk;
			gate_drive_fault_out <= gfault_reg;
		end
	end
	// ----------------------------------------
	// Gate monitors
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_mon
			sfcc_gate_monitor #(.WINDOW_CYC(WINDOW_CYC)) u_mon (
				.clk_in(clk_in),
				.resetn_in(resetn_in),
				.gate_cmd_in(gate_cmd_in[gi]),
				.gate_on_in(gate_on_in[gi]),
				.fault_out(gate_fault_pulse[gi])
			);
		end
	endgenerate
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_ctrl_write;
		wr_ctrl && (wr_data[FLD_SENSE_OFF_LSB +: 3] != sense_off);
	endsequence
	sequence s_outputs_follow;
		##2 (sense_fault_off_out == $past(wr_data[FLD_SENSE_OFF_LSB +: 3], 2));
	endsequence
	property p_sense_off;
		@(posedge clk_in) disable iff (!resetn_in)
		(sense_off[0] && sense_overcurrent_in[0]) |=> !sense_fault_out[0];
	endproperty
	a_sense_off: assert property (p_sense_off) else $error("phase A fault not suppressed");
	property p_sense_on;
		@(posedge clk_in) disable iff (!resetn_in)
		(!sense_off[2] && sense_overcurrent_in[2]) |=> sense_fault_out[2];
	endproperty
	a_sense_on: assert property (p_sense_on) else $error("phase C fault lost");
	property p_write_to_pins;
		@(posedge clk_in) disable iff (!resetn_in)
		s_ctrl_write |-> s_outputs_follow;
	endproperty
	a_write_to_pins: assert property (p_write_to_pins) else $error("write did not reach pins");
	property p_manual_short;
		@(posedge clk_in) disable iff (!resetn_in)
		(cal_bits[1] && !auto_mode) |=> amp_input_short_out[1] && !amp_auto_cal_out[1];
	endproperty
	a_manual_short: assert property (p_manual_short) else $error("manual short missing");
	property p_normal_amp;
		@(posedge clk_in) disable iff (!resetn_in)
		!cal_bits[0] |=> !amp_input_short_out[0] && !amp_auto_cal_out[0];
	endproperty
	a_normal_amp: assert property (p_normal_amp) else $error("amplifier not normal");
	property p_auto_cal;
		@(posedge clk_in) disable iff (!resetn_in)
		(cal_bits[2] && mode_reg[FLD_CAL_MODE]) |=> amp_auto_cal_out[2] && !amp_input_short_out[2];
	endproperty
	a_auto_cal: assert property (p_auto_cal) else $error("auto calibration missing");
	property p_ctrl_reset;
		@(posedge clk_in) !resetn_in |=> (ctrl_reg == RST_SENSE_CAL_CTRL) && (mode_reg == RST_CAL_MODE);
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value wrong");
	property p_ctrl_stable;
		@(posedge clk_in) disable iff (!resetn_in)
		!wr_ctrl |=> $stable(ctrl_reg);
	endproperty
	a_ctrl_stable: assert property (p_ctrl_stable) else $error("control changed without write");
	property p_pin_drive;
		@(posedge clk_in) disable iff (!resetn_in)
		!SERIAL_VARIANT |=> (hs_gate_source_current_out == $past(drive_strength_pin_in))
			&& (ls_gate_sink_current_out == $past(drive_strength_pin_in));
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("pin drive strength not applied");
	property p_reg_drive;
		@(posedge clk_in) disable iff (!resetn_in)
		SERIAL_VARIANT |=> ##1 (hs_gate_sink_current_out == $past(hs_reg[FLD_SINK_LSB +: 4]));
	endproperty
	a_reg_drive: assert property (p_reg_drive) else $error("register drive strength not applied");
	property p_gate_fault_sticky;
		@(posedge clk_in) disable iff (!resetn_in)
		gate_fault_pulse[3] |=> gfault_reg[3] ##1 gate_drive_fault_out[3];
	endproperty
	a_gate_fault_sticky: assert property (p_gate_fault_sticky) else $error("gate fault not held");
endmodule
`default_nettype wire

/* testbench/sfcc_host.sv */
// Purpose: Host controller model driving serial frames into the control block
// Assumes: Mode 1 serial, clock idle low, data launched on rise, sampled on fall
// Notes: Data line is inverted after release so a stale level is never read
`default_nettype none
module sfcc_host (
	// Clock
	input wire logic clk_in,
	// Serial pins
	input wire logic miso_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF_CYC = 4;
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// ----------------------------------------
	// One frame, MSB first; fewer than 16 bits makes a short frame
	// ----------------------------------------
	task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
		rdata = 8'h00;
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		repeat (HALF_CYC) @(posedge clk_in);
		for (int i = 15; i > 15 - nbits; i--) begin
			sclk_out <= 1'b1;
			mosi_out <= word[i];
			repeat (HALF_CYC) @(posedge clk_in);
			if (i < 8) rdata[i] = miso_in;
			sclk_out <= 1'b0;
			repeat (HALF_CYC) @(posedge clk_in);
		end
		cs_n_out <= 1'b1;
		mosi_out <= ~mosi_out;
		repeat (HALF_CYC) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* testbench/sense_fault_calibration_ctrl_bench.sv */
// Purpose: Self-checking bench for the sense fault and calibration control block
// Assumes: Serial and pin-strapped variants side by side, short gate drive window for simulation
// Notes: Table rows cover the control and mode codes, hand tests the rest
`default_nettype none
module sense_fault_calibration_ctrl_bench;
	import sfcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WIN = 8;
	// Rows: ctrl, mode, fault off, input short, auto cal
	localparam logic [39:0] ROWS [6] = '{40'h08_00_01_00_00, 40'h38_00_07_00_00,
		40'h07_00_00_07_00, 40'h05_80_00_00_05, 40'hc2_80_00_00_02, 40'h2a_7f_05_02_00};
	logic clk_in, resetn_in, sclk, cs_n, mosi, miso_out, miso_oe_out;
	logic [2:0] sense_overcurrent_in, sense_fault_out, sense_fault_off_out;
	logic [2:0] amp_input_short_out, amp_auto_cal_out;
	logic [3:0] drive_strength_pin_in, hs_src, hs_snk, ls_src, ls_snk;
	logic [3:0] p_hs_src, p_hs_snk, p_ls_src, p_ls_snk;
	logic [5:0] gate_cmd_in, gate_on_in, gate_drive_fault_out;
	logic [7:0] rdv;
	logic [39:0] row;
	int miscompares = 0;
	int total_checks = 0;
	// ----------------------------------------
	// Clock, parts
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	sfcc_host i_host (.clk_in(clk_in), .miso_in(miso_out), .sclk_out(sclk), .cs_n_out(cs_n),
		.mosi_out(mosi));
	sfcc_top #(.SERIAL_VARIANT(1'b1), .WINDOW_CYC(WIN)) i_dut (.clk_in(clk_in),
		.resetn_in(resetn_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
		.miso_out(miso_out), .miso_oe_out(miso_oe_out),
		.sense_overcurrent_in(sense_overcurrent_in), .sense_fault_out(sense_fault_out),
		.sense_fault_off_out(sense_fault_off_out), .amp_input_short_out(amp_input_short_out),
		.amp_auto_cal_out(amp_auto_cal_out), .drive_strength_pin_in(drive_strength_pin_in),
		.gate_cmd_in(gate_cmd_in), .gate_on_in(gate_on_in),
		.hs_gate_source_current_out(hs_src), .hs_gate_sink_current_out(hs_snk),
		.ls_gate_source_current_out(ls_src), .ls_gate_sink_current_out(ls_snk),
		.gate_drive_fault_out(gate_drive_fault_out));
	sfcc_top #(.SERIAL_VARIANT(1'b0), .WINDOW_CYC(WIN)) i_dut_pin (.clk_in(clk_in),
		.resetn_in(resetn_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(),
		.miso_oe_out(), .sense_overcurrent_in(sense_overcurrent_in), .sense_fault_out(),
		.sense_fault_off_out(), .amp_input_short_out(), .amp_auto_cal_out(),
		.drive_strength_pin_in(drive_strength_pin_in), .gate_cmd_in(gate_cmd_in),
		.gate_on_in(gate_on_in), .hs_gate_source_current_out(p_hs_src),
		.hs_gate_sink_current_out(p_hs_snk), .ls_gate_source_current_out(p_ls_src),
		.ls_gate_sink_current_out(p_ls_snk), .gate_drive_fault_out());
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] addr, input logic [7:0] data, input int nbits);
		logic [7:0] unused;
		i_host.frame({1'b0, addr, 1'b0, data}, nbits, unused);
	endtask
	task automatic rd(input logic [5:0] addr, output logic [7:0] data);
		i_host.frame({1'b1, addr, 9'h000}, 16, data);
	endtask
	task automatic do_reset();
		@(posedge clk_in);
		resetn_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(negedge clk_in);
	endtask
	task automatic check_idle();
		check({7'h00, miso_oe_out}, 8'h00);
		check({5'h00, sense_fault_off_out}, 8'h00);
		check({5'h00, amp_input_short_out | amp_auto_cal_out}, 8'h00);
		check({hs_snk, hs_src}, 8'h00);
		check({2'h0, gate_drive_fault_out}, 8'h00);
		for (int a = 16; a < 21; a++) begin
			rd(a[5:0], rdv);
			check(rdv, 8'h00);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk_in);
		miscompares++;
		wrap_up();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn_in = 1'b0;
		sense_overcurrent_in = 3'h0;
		drive_strength_pin_in = 4'h9;
		gate_cmd_in = 6'h00;
		gate_on_in = 6'h00;
		do_reset();
		check_idle();
		foreach (ROWS[r]) begin
			row = ROWS[r];
			wr(ADDR_CAL_MODE, row[31:24], 16);
			wr(ADDR_SENSE_CAL_CTRL, row[39:32], 16);
			@(posedge clk_in);
			sense_overcurrent_in <= 3'h7;
			repeat (3) @(negedge clk_in);
			check({5'h00, sense_fault_off_out}, row[23:16]);
			check({5'h00, sense_fault_out}, ~row[23:16] & 8'h07);
			check({5'h00, amp_input_short_out}, row[15:8]);
			check({5'h00, amp_auto_cal_out}, row[7:0]);
			rd(ADDR_SENSE_CAL_CTRL, rdv);
			check(rdv, row[39:32]);
			rd(ADDR_CAL_MODE, rdv);
			check(rdv, row[31:24]);
		end
		wr(ADDR_SENSE_CAL_CTRL, 8'h00, 8);
		rd(ADDR_SENSE_CAL_CTRL, rdv);
		check(rdv, 8'h2a);
		wr(6'h20, 8'h5a, 16);
		rd(6'h20, rdv);
		check(rdv, 8'h00);
		wr(ADDR_HS_DRIVE, 8'ha5, 16);
		wr(ADDR_LS_DRIVE, 8'h3c, 16);
		@(negedge clk_in);
		check({hs_snk, hs_src}, 8'ha5);
		check({ls_snk, ls_src}, 8'h3c);
		check({p_hs_snk, p_hs_src}, 8'h99);
		check({p_ls_snk, p_ls_src}, 8'h99);
		@(posedge clk_in);
		gate_cmd_in <= 6'h09;
		gate_on_in <= 6'h00;
		repeat (3) @(posedge clk_in);
		gate_on_in <= 6'h01;
		repeat (WIN - 3) @(negedge clk_in);
		check({2'h0, gate_drive_fault_out}, 8'h00);
		repeat (WIN + 4) @(negedge clk_in);
		check({2'h0, gate_drive_fault_out}, 8'h08);
		@(posedge clk_in);
		gate_cmd_in <= 6'h00;
		fork
			rd(ADDR_GATE_FAULT, rdv);
			begin
				repeat (8) @(negedge clk_in);
				check({7'h00, miso_oe_out}, 8'h01);
			end
		join
		check(rdv, 8'h08);
		rd(ADDR_GATE_FAULT, rdv);
		check(rdv, 8'h00);
		check({2'h0, gate_drive_fault_out}, 8'h00);
		do_reset();
		check_idle();
		wrap_up();
	end
endmodule
`default_nettype wire
